/* File: cssi_status_irq.v */
// Status pin routing and sticky, maskable interrupt logic with a Wishbone slave.
// Notes on behaviour
// - Four status pins each pick one signal, a driver type and a polarity.
// - An asserted selected signal drives its pin high unless set active low.
// - Sources include XO and TCXO signal loss, EEPROM active and interrupt flag.
// - Per APLL: lock detect, VCO calibration active, N divider halved.
// - Per reference: divider halved, amplitude, frequency, pulse, phase faults, timer.
// - Per DPLL: four halved dividers, ref selected, holdover, switchover, history, frequency lock loss.
// - Any status pin may carry the interrupt by selecting it.
// - When enabled, any indicator combination may raise the interrupt flag.
// - Each indicator has a mask; masked ones never reach the interrupt.
// - Each unmasked indicator may be inverted before the combining gate.
// - Indicators combine by selectable AND or OR onto the interrupt pin.
// - Asserted flags set sticky bits; host writing zero clears them.
// - Missing and runt pulse flags of each reference are ORed together.
// - PLL lock flags are visible on status pins and in a register.
`timescale 1ns/1ps
`include "cssi_defines.vh"
module cssi_status_irq #(
  parameter NREF = 4,
  parameter NPLL = 2
) (
  input wire clk_sys_i, // System clock, 20 MHz.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire wb_cyc_i, // Wishbone cycle.
  input wire wb_stb_i, // Wishbone strobe.
  input wire wb_we_i, // Wishbone write enable.
  input wire [5:0] wb_adr_i, // Wishbone byte address.
  input wire [3:0] wb_sel_i, // Wishbone byte enables.
  input wire [31:0] wb_dat_i, // Wishbone write data.
  output reg [31:0] wb_dat_o, // Wishbone read data.
  output reg wb_ack_o, // Wishbone acknowledge.
  input wire xo_loss_of_signal_flag_i, // XO input signal lost.
  input wire tcxo_loss_of_signal_flag_i, // TCXO input signal lost.
  input wire eeprom_active_i, // Nonvolatile memory busy.
  input wire [NPLL-1:0] apll_lock_i, // APLL lock detected.
  input wire [NPLL-1:0] vco_cal_active_i, // VCO calibration running.
  input wire [NPLL-1:0] apll_ndiv_pulse_i, // APLL N divider output strobe.
  input wire [NREF-1:0] ref_mondiv_pulse_i, // Monitor divider strobe per reference_input_n.
  input wire [NREF-1:0] ref_amp_fault_i, // Amplitude monitor fault.
  input wire [NREF-1:0] ref_freq_fault_i, // Frequency monitor fault.
  input wire [NREF-1:0] ref_missing_fault_i, // Missing pulse monitor fault.
  input wire [NREF-1:0] ref_runt_fault_i, // Early pulse monitor fault.
  input wire [NREF-1:0] ref_valid_timer_i, // Validation timer running.
  input wire [NREF-1:0] ref_phase_fault_i, // Phase validation fault.
  input wire [NPLL-1:0] dpll_rdiv_pulse_i, // DPLL R divider strobe.
  input wire [NPLL-1:0] dpll_refn_pulse_i, // DPLL REF N divider strobe.
  input wire [NPLL-1:0] dpll_tcxom_pulse_i, // DPLL TCXO M divider strobe.
  input wire [NPLL-1:0] dpll_tcxon_pulse_i, // DPLL TCXO N divider strobe.
  input wire [NPLL-1:0] dpll_ref_selected_i, // DPLL has a reference selected.
  input wire [NPLL-1:0] dpll_holdover_i, // DPLL in holdover.
  input wire [NPLL-1:0] dpll_switchover_i, // DPLL switchover event.
  input wire [NPLL-1:0] dpll_history_update_i, // Tuning history updated.
  input wire [NPLL-1:0] dpll_freq_lock_loss_flag_i, // DPLL frequency lock lost.
  input wire [NPLL-1:0] dpll_sel_loss_of_signal_flag_i, // DPLL selected input lost.
  output reg [`CSSI_NPINS-1:0] status_pin_o, // Status pin output level.
  output reg [`CSSI_NPINS-1:0] status_pin_oe_n_o, // Status pin enable, low drives.
  output reg combined_irq_flag_o // Interrupt flag as computed.
);

  localparam NLVL = 3 + 2 * NPLL + 6 * NREF + 6 * NPLL;
  localparam NPUL = NPLL + NREF + 4 * NPLL;

  // Monitor levels come from other clock domains, so all pass two flip-flops.
  wire [NLVL-1:0] lvl_async;
  wire [NLVL-1:0] lvl;
  assign lvl_async = {dpll_sel_loss_of_signal_flag_i, dpll_freq_lock_loss_flag_i,
    dpll_history_update_i, dpll_switchover_i, dpll_holdover_i, dpll_ref_selected_i,
    ref_phase_fault_i, ref_valid_timer_i, ref_runt_fault_i, ref_missing_fault_i,
    ref_freq_fault_i, ref_amp_fault_i, vco_cal_active_i, apll_lock_i,
    eeprom_active_i, tcxo_loss_of_signal_flag_i, xo_loss_of_signal_flag_i};

  cssi_sync2 #(
    .WIDTH(NLVL)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(lvl_async),
    .sync_o(lvl)
  );

  // Unpack the synchronised levels in the same order they were packed.
  wire s_xo_loss = lvl[0];
  wire s_tcxo_loss = lvl[1];
  wire s_eeprom = lvl[2];
  wire [NPLL-1:0] s_alock = lvl[3 +: NPLL];
  wire [NPLL-1:0] s_vcocal = lvl[3 + NPLL +: NPLL];
  localparam RB = 3 + 2 * NPLL;
  wire [NREF-1:0] s_amp = lvl[RB +: NREF];
  wire [NREF-1:0] s_freq = lvl[RB + NREF +: NREF];
  wire [NREF-1:0] s_miss = lvl[RB + 2 * NREF +: NREF];
  wire [NREF-1:0] s_runt = lvl[RB + 3 * NREF +: NREF];
  wire [NREF-1:0] s_valt = lvl[RB + 4 * NREF +: NREF];
  wire [NREF-1:0] s_phase = lvl[RB + 5 * NREF +: NREF];
  localparam DB = RB + 6 * NREF;
  wire [NPLL-1:0] s_refsel = lvl[DB +: NPLL];
  wire [NPLL-1:0] s_hold = lvl[DB + NPLL +: NPLL];
  wire [NPLL-1:0] s_swo = lvl[DB + 2 * NPLL +: NPLL];
  wire [NPLL-1:0] s_hist = lvl[DB + 3 * NPLL +: NPLL];
  wire [NPLL-1:0] s_fll = lvl[DB + 4 * NPLL +: NPLL];
  wire [NPLL-1:0] s_selloss = lvl[DB + 5 * NPLL +: NPLL];

  // Divider strobes are on this clock; each toggles a flop to form div-by-2.
  wire [NPUL-1:0] pulse_in;
  reg [NPUL-1:0] half;
  assign pulse_in = {dpll_tcxon_pulse_i, dpll_tcxom_pulse_i, dpll_refn_pulse_i,
    dpll_rdiv_pulse_i, ref_mondiv_pulse_i, apll_ndiv_pulse_i};

  genvar g;
  generate
    for (g = 0; g < NPUL; g = g + 1) begin : g_half
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          half[g] <= 1'b0;
        end else if (pulse_in[g]) begin
          half[g] <= ~half[g];
        end
      end
    end
  endgenerate

  localparam HR = NPLL;
  localparam HD = NPLL + NREF;

  // Register state.
  reg [`CSSI_CFG_W-1:0] pin_cfg [0:`CSSI_NPINS-1];
  reg [1:0] irq_ctrl;
  reg [`CSSI_NIND-1:0] irq_mask;
  reg [`CSSI_NIND-1:0] irq_inv;
  reg [`CSSI_NIND-1:0] sticky;
  reg irq_flag;

  // Status source vector that every pin selector indexes.
  wire [`CSSI_NSRC-1:0] src;
  assign src[`CSSI_SRC_XO] = s_xo_loss;
  assign src[`CSSI_SRC_TCXO] = s_tcxo_loss;
  assign src[`CSSI_SRC_EEPROM] = s_eeprom;
  assign src[`CSSI_SRC_IRQ] = irq_flag;

  generate
    for (g = 0; g < NPLL; g = g + 1) begin : g_apll
      // Lock detect is presented as lock, matching the status table polarity.
      assign src[`CSSI_SRC_APLL + g * `CSSI_APLL_STRIDE] = s_alock[g];
      assign src[`CSSI_SRC_APLL + g * `CSSI_APLL_STRIDE + 1] = s_vcocal[g];
      assign src[`CSSI_SRC_APLL + g * `CSSI_APLL_STRIDE + 2] = half[g];
    end
    for (g = 0; g < NREF; g = g + 1) begin : g_ref
      assign src[`CSSI_SRC_REF + g * `CSSI_REF_STRIDE] = half[HR + g];
      assign src[`CSSI_SRC_REF + g * `CSSI_REF_STRIDE + 1] = s_amp[g];
      assign src[`CSSI_SRC_REF + g * `CSSI_REF_STRIDE + 2] = s_freq[g];
      // Both monitors share one window detector, so one merged flag suffices.
      assign src[`CSSI_SRC_REF + g * `CSSI_REF_STRIDE + 3] = s_miss[g] | s_runt[g];
      assign src[`CSSI_SRC_REF + g * `CSSI_REF_STRIDE + 4] = s_valt[g];
      assign src[`CSSI_SRC_REF + g * `CSSI_REF_STRIDE + 5] = s_phase[g];
    end
    for (g = 0; g < NPLL; g = g + 1) begin : g_dpll
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE] = half[HD + g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 1] = half[HD + NPLL + g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 2] = half[HD + 2 * NPLL + g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 3] = half[HD + 3 * NPLL + g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 4] = s_refsel[g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 5] = s_hold[g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 6] = s_swo[g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 7] = s_hist[g];
      assign src[`CSSI_SRC_DPLL + g * `CSSI_DPLL_STRIDE + 8] = s_fll[g];
    end
  endgenerate

  // Raw interrupt indicators, each active when its fault is present.
  wire [`CSSI_NIND-1:0] ind_raw;
  assign ind_raw[`CSSI_IND_XO] = s_xo_loss;
  assign ind_raw[`CSSI_IND_TCXO] = s_tcxo_loss;
  assign ind_raw[`CSSI_IND_SELLOSS +: 2] = s_selloss;
  assign ind_raw[`CSSI_IND_DLOL +: 2] = s_fll;
  assign ind_raw[`CSSI_IND_ALOL +: 2] = ~s_alock;
  assign ind_raw[`CSSI_IND_HOLD +: 2] = s_hold;
  assign ind_raw[`CSSI_IND_SWO +: 2] = s_swo;

  // Polarity is adjusted before capture so the sticky bits feed the gate.
  wire [`CSSI_NIND-1:0] ind_adj = ind_raw ^ irq_inv;

  // Bus decode; a new request is served once, in the cycle before ack rises.
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [3:0] idx = wb_adr_i[5:2];
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wdat = wb_dat_i[15:0];

  // Write-zero clear; a bit that sets in the same cycle stays set.
  wire clr_wr = wr & (idx == `CSSI_IDX_STICKY);
  wire [`CSSI_NIND-1:0] clr = clr_wr ? (wmask[`CSSI_NIND-1:0] & ~wdat[`CSSI_NIND-1:0])
    : {`CSSI_NIND{1'b0}};
  wire [`CSSI_NIND-1:0] next_sticky = (sticky & ~clr) | ind_adj;

  // Combining gate; masked bits are neutral for either function.
  wire [`CSSI_NIND-1:0] unmasked = sticky & ~irq_mask;
  wire and_hit = (|(~irq_mask)) & (&(sticky | irq_mask));
  wire or_hit = |unmasked;
  wire gate = irq_ctrl[`CSSI_AND_BIT] ? and_hit : or_hit;
  wire next_irq = irq_ctrl[`CSSI_EN_BIT] & gate;

  // Sticky and interrupt flag update.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sticky <= {`CSSI_NIND{1'b0}};
      irq_flag <= 1'b0;
      combined_irq_flag_o <= 1'b0;
    end else begin
      sticky <= next_sticky;
      irq_flag <= next_irq;
      combined_irq_flag_o <= next_irq;
    end
  end

  // Control registers; only the byte lanes that carry fields are honoured.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_ctrl <= `CSSI_CTRL_RST;
      irq_mask <= `CSSI_MASK_RST;
      irq_inv <= `CSSI_INV_RST;
    end else if (wr) begin
      case (idx)
        `CSSI_IDX_CTRL: begin
          if (wb_sel_i[0]) begin
            irq_ctrl <= wdat[1:0];
          end
        end
        `CSSI_IDX_MASK: begin
          irq_mask <= (irq_mask & ~wmask[`CSSI_NIND-1:0])
            | (wdat[`CSSI_NIND-1:0] & wmask[`CSSI_NIND-1:0]);
        end
        `CSSI_IDX_INV: begin
          irq_inv <= (irq_inv & ~wmask[`CSSI_NIND-1:0])
            | (wdat[`CSSI_NIND-1:0] & wmask[`CSSI_NIND-1:0]);
        end
        default: begin
          irq_ctrl <= irq_ctrl;
        end
      endcase
    end
  end

  // Pin configuration registers and pin drivers, one copy per pin.
  generate
    for (g = 0; g < `CSSI_NPINS; g = g + 1) begin : g_pin
      wire [5:0] psel = pin_cfg[g][`CSSI_SEL_HI:`CSSI_SEL_LO];
      // Out-of-range selections read as an idle, deasserted signal.
      wire asserted = (psel < `CSSI_NSRC) ? src[psel] : 1'b0;
      wire level = asserted ^ pin_cfg[g][`CSSI_POL_BIT];
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          pin_cfg[g] <= `CSSI_CFG_RST;
        end else if (wr && idx == g) begin
          pin_cfg[g] <= (pin_cfg[g] & ~wmask[`CSSI_CFG_W-1:0])
            | (wdat[`CSSI_CFG_W-1:0] & wmask[`CSSI_CFG_W-1:0]);
        end
      end
      // Open drain only pulls low and releases the pin for a high level.
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          status_pin_o[g] <= 1'b0;
          status_pin_oe_n_o[g] <= 1'b0;
        end else begin
          status_pin_o[g] <= level;
          status_pin_oe_n_o[g] <= pin_cfg[g][`CSSI_OD_BIT] & level;
        end
      end
    end
  endgenerate

  // Read multiplexer; unmapped words answer zero with a normal ack.
  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    case (idx)
      `CSSI_IDX_CTRL: begin
        rd[1:0] = irq_ctrl;
      end
      `CSSI_IDX_MASK: begin
        rd[`CSSI_NIND-1:0] = irq_mask;
      end
      `CSSI_IDX_INV: begin
        rd[`CSSI_NIND-1:0] = irq_inv;
      end
      `CSSI_IDX_STICKY: begin
        rd[`CSSI_NIND-1:0] = sticky;
      end
      `CSSI_IDX_LIVE: begin
        rd[`CSSI_NIND-1:0] = ind_raw;
        rd[`CSSI_LIVE_IRQ_BIT] = irq_flag;
      end
      default: begin
        if (idx < `CSSI_NPINS) begin
          rd[`CSSI_CFG_W-1:0] = pin_cfg[idx[1:0]];
        end
      end
    endcase
  end

  // Ack one cycle after the request; it drops the cycle after it is given.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd;
      end
    end
  end

endmodule // cssi_status_irq

/* File: cssi_defines.vh */
// Constants for the clock synchronizer status pin and interrupt block.
`ifndef CSSI_DEFINES_VH
`define CSSI_DEFINES_VH

// Word indices of the registers; byte address is four times the index.
`define CSSI_IDX_PIN0 4'h0
`define CSSI_IDX_CTRL 4'h4
`define CSSI_IDX_MASK 4'h5
`define CSSI_IDX_INV 4'h6
`define CSSI_IDX_STICKY 4'h7
`define CSSI_IDX_LIVE 4'h8
`define CSSI_NPINS 4

// Status pin configuration fields.
`define CSSI_CFG_W 10
`define CSSI_SEL_HI 5
`define CSSI_SEL_LO 0
`define CSSI_POL_BIT 8
`define CSSI_OD_BIT 9
`define CSSI_CFG_RST 10'h000

// Interrupt control fields.
`define CSSI_EN_BIT 0
`define CSSI_AND_BIT 1
`define CSSI_CTRL_RST 2'h0

// Interrupt indicator vector layout and reset values.
`define CSSI_NIND 12
`define CSSI_IND_XO 0
`define CSSI_IND_TCXO 1
`define CSSI_IND_SELLOSS 2
`define CSSI_IND_DLOL 4
`define CSSI_IND_ALOL 6
`define CSSI_IND_HOLD 8
`define CSSI_IND_SWO 10
`define CSSI_MASK_RST 12'hfff
`define CSSI_INV_RST 12'h000
`define CSSI_LIVE_IRQ_BIT 12

// Status source numbering for the pin selectors.
`define CSSI_NSRC 52
`define CSSI_SRC_XO 0
`define CSSI_SRC_TCXO 1
`define CSSI_SRC_EEPROM 2
`define CSSI_SRC_IRQ 3
`define CSSI_SRC_APLL 4
`define CSSI_APLL_STRIDE 3
`define CSSI_SRC_REF 10
`define CSSI_REF_STRIDE 6
`define CSSI_SRC_DPLL 34
`define CSSI_DPLL_STRIDE 9

`endif

/* File: cssi_sync2.v */
// Two flip-flop synchroniser for a bundle of independent level signals.
`timescale 1ns/1ps
module cssi_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk_sys_i, // System clock.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire [WIDTH-1:0] async_i, // Levels from another domain.
  output reg [WIDTH-1:0] sync_o // Levels safe to use in this domain.
);

  reg [WIDTH-1:0] meta;

  // The first stage feeds only the second stage, so metastability never leaks.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // cssi_sync2

/* File: cssi_status_irq_assertions.sv */
// Port-level checks for the status pin and interrupt block, bound to its top module.
`timescale 1ns/1ps
`include "cssi_defines.vh"
module cssi_status_irq_chk (
  input wire clk_sys_i, // System clock.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire wb_cyc_i, // Bus cycle.
  input wire wb_stb_i, // Bus strobe.
  input wire wb_we_i, // Bus write enable.
  input wire [5:0] wb_adr_i, // Bus byte address.
  input wire [3:0] wb_sel_i, // Byte enables.
  input wire [31:0] wb_dat_i, // Write data.
  input wire [31:0] wb_dat_o, // Read data.
  input wire wb_ack_o, // Acknowledge.
  input wire xo_loss_of_signal_flag_i, // XO input signal lost.
  input wire [`CSSI_NPINS-1:0] status_pin_o, // Pin levels.
  input wire [`CSSI_NPINS-1:0] status_pin_oe_n_o, // Pin enables, low drives.
  input wire combined_irq_flag_o // Interrupt flag.
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  reg [9:0] cfg0;
  reg [1:0] ctrl;
  reg [11:0] mask;
  reg inv0;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire [3:0] ix = wb_adr_i[5:2];
  // Shadow copies of the registers the checks lean on, updated at the edge a write is taken.
  // Only pin 0 is shadowed; the bench routes the interrupt there.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg0 <= 10'h000;
      ctrl <= 2'h0;
      mask <= 12'hfff;
      inv0 <= 1'b0;
    end else if (wr) begin
      if (ix == `CSSI_IDX_PIN0 && wb_sel_i[0]) cfg0[7:0] <= wb_dat_i[7:0];
      if (ix == `CSSI_IDX_PIN0 && wb_sel_i[1]) cfg0[9:8] <= wb_dat_i[9:8];
      if (ix == `CSSI_IDX_CTRL && wb_sel_i[0]) ctrl <= wb_dat_i[1:0];
      if (ix == `CSSI_IDX_MASK && wb_sel_i[0]) mask[7:0] <= wb_dat_i[7:0];
      if (ix == `CSSI_IDX_MASK && wb_sel_i[1]) mask[11:8] <= wb_dat_i[11:8];
      if (ix == `CSSI_IDX_INV && wb_sel_i[0]) inv0 <= wb_dat_i[0];
    end
  end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("acknowledge without a request");
  AST_LIVE_FLAG: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && ix == `CSSI_IDX_LIVE |=> wb_dat_o[12] == $past(combined_irq_flag_o))
    else $error("live register flag differs from interrupt flag");
  AST_DISABLED_LOW: assert property (!ctrl[0] |=> !combined_irq_flag_o)
    else $error("interrupt flag high while disabled");
  AST_ALL_MASKED: assert property (mask == 12'hfff |=> !combined_irq_flag_o)
    else $error("interrupt flag high with every indicator masked");
  AST_OR_RAISE: assert property ((ctrl == 2'h1 && !mask[0] && !inv0
    && xo_loss_of_signal_flag_i)[*5] |=> combined_irq_flag_o)
    else $error("unmasked XO loss did not raise the interrupt");
  AST_IRQ_PIN: assert property (cfg0[5:0] == 6'h03 && !cfg0[9]
    |=> status_pin_o[0] == ($past(combined_irq_flag_o) ^ $past(cfg0[8])))
    else $error("interrupt pin level wrong");
  AST_PUSH_PULL: assert property (!cfg0[9] |=> !status_pin_oe_n_o[0])
    else $error("push-pull pin not driven");
  AST_OD_RELEASE: assert property (cfg0[9] && cfg0[5:0] == 6'h03
    |=> status_pin_oe_n_o[0] == ($past(combined_irq_flag_o) ^ $past(cfg0[8])))
    else $error("open-drain pin enable wrong");
endmodule // cssi_status_irq_chk
bind cssi_status_irq cssi_status_irq_chk u_chk (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .xo_loss_of_signal_flag_i,
  .status_pin_o, .status_pin_oe_n_o, .combined_irq_flag_o);

/* File: cssi_host_model.sv */
// Host processor model: a classic bus master with an interrupt service routine.
`timescale 1ns/1ps
module cssi_host_model (
  input wire clk_sys_i, // System clock.
  input wire wb_ack_i, // Acknowledge from the block.
  input wire [31:0] wb_dat_i, // Read data from the block.
  output reg wb_cyc_o = 1'b0, // Bus cycle.
  output reg wb_stb_o = 1'b0, // Strobe.
  output reg wb_we_o = 1'b0, // Write enable.
  output reg [5:0] wb_adr_o = 6'h00, // Byte address.
  output reg [3:0] wb_sel_o = 4'h0, // Byte enables.
  output reg [31:0] wb_dat_o = 32'h0, // Write data.
  output reg timeout_o = 1'b0 // Set when the block never answered.
);
  int idle = 0; // Extra idle cycles after each transfer, so pacing varies.
  // One classic cycle; everything holds until ack is seen at a rising edge.
  task xfer(input we, input [5:0] ad, input [3:0] se, input [31:0] d, output [31:0] q);
    int n;
    begin
      n = 0;
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= ad;
      wb_sel_o <= se;
      wb_dat_o <= d;
      @(posedge clk_sys_i);
      while (wb_ack_i !== 1'b1 && n < 20) begin
        n++;
        @(posedge clk_sys_i);
      end
      timeout_o <= (n == 20);
      q = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      // A released data bus must not keep showing the last word.
      wb_dat_o <= ~d;
      repeat (idle + 1) @(posedge clk_sys_i);
    end
  endtask
  // Interrupt service: read the sticky bits, then write zero over exactly those set.
  task service(output [31:0] seen);
    reg [31:0] q;
    begin
      xfer(1'b0, 6'h1c, 4'hf, 32'h0, seen);
      xfer(1'b1, 6'h1c, 4'hf, ~seen, q);
    end
  endtask
endmodule // cssi_host_model

/* File: tb_top.sv */
// Self-checking bench for the status pin and interrupt block.
`timescale 1ns/1ps
module tb_top;
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [42:0] a = 43'h18; // Async status levels; both APLLs start locked.
  reg [13:0] p = 14'h0; // Divider strobes.
  reg [13:0] h = 14'h0; // Expected divide-by-2 states.
  wire cyc, stb, we, ack, irq, tmo;
  wire [5:0] adr;
  wire [3:0] sel, pin, oe_n;
  wire [31:0] wd, rd;
  int n_fail = 0;
  int n_compared = 0;
  int s, i;
  reg [31:0] q;
  reg [11:0] m, v, f;
  reg po, od, e;
  always #25 clk_sys_i = ~clk_sys_i;
  cssi_status_irq dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .xo_loss_of_signal_flag_i(a[0]),
    .tcxo_loss_of_signal_flag_i(a[1]), .eeprom_active_i(a[2]), .apll_lock_i(a[4:3]),
    .vco_cal_active_i(a[6:5]), .apll_ndiv_pulse_i(p[1:0]), .ref_mondiv_pulse_i(p[5:2]),
    .ref_amp_fault_i(a[10:7]), .ref_freq_fault_i(a[14:11]), .ref_missing_fault_i(a[18:15]),
    .ref_runt_fault_i(a[22:19]), .ref_valid_timer_i(a[26:23]), .ref_phase_fault_i(a[30:27]),
    .dpll_rdiv_pulse_i(p[7:6]), .dpll_refn_pulse_i(p[9:8]), .dpll_tcxom_pulse_i(p[11:10]),
    .dpll_tcxon_pulse_i(p[13:12]), .dpll_ref_selected_i(a[32:31]),
    .dpll_holdover_i(a[34:33]), .dpll_switchover_i(a[36:35]),
    .dpll_history_update_i(a[38:37]), .dpll_freq_lock_loss_flag_i(a[40:39]),
    .dpll_sel_loss_of_signal_flag_i(a[42:41]), .status_pin_o(pin),
    .status_pin_oe_n_o(oe_n), .combined_irq_flag_o(irq));
  cssi_host_model host (.clk_sys_i(clk_sys_i), .wb_ack_i(ack), .wb_dat_i(rd),
    .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
    .wb_dat_o(wd), .timeout_o(tmo));
  // Expected level of status source s; unused numbers read as a constant 0.
  function automatic logic src(input int s);
    int k;
    int j;
    k = s < 10 ? (s - 4) / 3 : s < 34 ? (s - 10) / 6 : (s - 34) / 9;
    j = s < 10 ? (s - 4) % 3 : s < 34 ? (s - 10) % 6 : (s - 34) % 9;
    if (s < 3) return a[s];
    if (s < 4 || s > 51) return 1'b0;
    if (s < 10) return j == 2 ? h[k] : a[3 + 2 * j + k];
    if (s < 34) return j == 0 ? h[2 + k] : j == 3 ? a[15 + k] | a[19 + k]
      : a[(j < 3 ? 3 : 7) + 4 * j + k];
    return j < 4 ? h[6 + 2 * j + k] : a[23 + 2 * j + k];
  endfunction
  // Drive the async levels so that the twelve indicators read x.
  task setind(input [11:0] x);
    a <= {x[3:2], x[5:4], a[38:37], x[11:10], x[9:8], a[32:5], ~x[7:6], a[2], x[1:0]};
  endtask
  // Count a comparison and report a mismatch at once.
  task chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task rdc(input [5:0] ad, input [31:0] ex);
    reg [31:0] r;
    host.xfer(1'b0, ad, 4'hf, 32'h0, r);
    chk(r, ex);
  endtask
  task wr(input [5:0] ad, input [31:0] d, input [3:0] se = 4'hf);
    reg [31:0] r;
    host.xfer(1'b1, ad, se, d, r);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // A bus wait that ran out ends the run as a failure.
  always @(posedge tmo) begin
    n_fail++;
    report_and_stop;
  end
  initial begin
    i = $urandom(43024);
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // Writes to the read-only and unmapped words must leave no trace; the lock
    // synchronisers leave reset showing unlock, so those sticky bits are set.
    wr(6'h20, 32'hffff_ffff);
    wr(6'h24, 32'hffff_ffff);
    for (s = 0; s < 16; s++) rdc(6'(s * 4), s == 5 ? 32'hfff : s == 7 ? 32'hc0 : 32'h0);
    wr(6'h14, 32'h0, 4'h1);
    rdc(6'h14, 32'hf00);
    $display("register test done");
    // Every source number, on a rotating pin, with random polarity and driver type.
    for (s = 0; s < 64; s++) begin
      po = 1'($urandom);
      od = 1'($urandom);
      wr(6'(s % 4 * 4), {22'h0, od, po, 2'h0, 6'(s)});
      a <= 43'({$urandom, $urandom});
      p <= 14'($urandom);
      @(posedge clk_sys_i);
      h = h ^ p;
      p <= 14'h0;
      repeat (4) @(posedge clk_sys_i);
      e = src(s) ^ po;
      chk(oe_n[s % 4], od & e);
      if (!od || !e) chk(pin[s % 4], e);
    end
    $display("pin routing test done");
    // Random mask and inversion, enable and combine mode from i % 4; every enable and mode pair is visited.
    for (i = 0; i < 12; i++) begin
      host.idle = i % 3;
      m = 12'($urandom) & {11'h7ff, i != 1};
      v = 12'($urandom) & {11'h7ff, i != 1};
      f = i % 3 == 0 ? ~m : 12'($urandom) | {11'h0, i == 1};
      wr(6'h00, {22'h0, 2'($urandom), 8'h03});
      wr(6'h18, {20'h0, v});
      wr(6'h14, {20'h0, m});
      wr(6'h10, 32'(i % 4));
      setind(v);
      repeat (4) @(posedge clk_sys_i);
      wr(6'h1c, 32'h0);
      rdc(6'h1c, 32'h0);
      setind(v ^ f);
      repeat (6) @(posedge clk_sys_i);
      rdc(6'h1c, {20'h0, f});
      // A clear that meets a fault still present must lose to the set.
      wr(6'h1c, 32'h0);
      rdc(6'h1c, {20'h0, f});
      e = i[0] & (i[1] ? m != 12'hfff && &(f | m) : |(f & ~m));
      rdc(6'h20, {19'h0, e, v ^ f});
      chk(irq, e);
      setind(v);
      repeat (6) @(posedge clk_sys_i);
      rdc(6'h1c, {20'h0, f});
      host.service(q);
      chk(q, {20'h0, f});
      rdc(6'h1c, 32'h0);
      chk(irq, 1'b0);
    end
    $display("interrupt test done");
    report_and_stop;
  end
endmodule // tb_top
